//--- verilog/cpw_consts.vh
// Constants for the clock select, power-down and wake-up block
// Notes on behaviour
// - Clock-on sleep ends on external wake or timer four request flag set.
// - All-stop sleep ends on external wake, or on a timer four flag already set when it is entered.
// - Enabled key pin wakes device on high-to-low falling edge.
// - Interrupt-zero pin wakes on chosen level; wake does not set its request flag.
// - Timer four underflow flag wakes device from clock-on sleep; all-stop sleep only if set at entry.
// - Sleep entered with timer four flag already one returns immediately.
// - Key wake enable register written from accumulator, readable back.
// - Pull-up register written from accumulator by its own transfer.
// - Clock mode register governs oscillators; main selected after cold start.
// - Setting select bit switches instruction clock source to sub oscillator.
// - Warm start keeps the clock source selected before sleep.
// - Instruction clock is selected oscillator divided by three.
// - Select bit moves to sub clock; main-stop bit then stops main oscillator.
// - Warm start restarts at page 0 address 0 with power-down flag one; cold clears.
`ifndef CPW_CONSTS_VH
`define CPW_CONSTS_VH
`define CPW_MODE_W      3
`define CPW_MODE_RST    3'h0
`define CPW_SEL_BIT     0
`define CPW_STOP_BIT    1
`define CPW_KEY_W       8
`define CPW_KEY_RST     8'h00
`define CPW_IRQ_LVL_BIT 2
`define CPW_DIV         3
`define CPW_STAB_CYC    16
`endif

//--- verilog/cpw_div3.v
// Divide-by-three instruction clock enable generator
`timescale 1ns/10ps
module cpw_div3 (
	input  wire clk,
	input  wire rst,
	input  wire tick,
	input  wire run,
	output reg  pulse
);
`include "cpw_consts.vh"
	reg [1:0] cnt_r;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 2'h0;
			pulse <= 1'b0;
		end else begin
			pulse <= 1'b0;
			if (!run) begin
				cnt_r <= 2'h0;
			end else if (tick) begin
				if ({30'h00000000, cnt_r} == `CPW_DIV - 1) begin
					cnt_r <= 2'h0;
					pulse <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 2'h1;
				end
			end
		end
	end
endmodule // cpw_div3

//--- verilog/cpw_top.v
// Clock selection, power-down sequencing and wake-up logic
`timescale 1ns/10ps
`include "cpw_consts.vh"
module cpw_top #(
	parameter STAB_CYC = `CPW_STAB_CYC
) (
	// Clock and reset
	input  wire       CLK,
	input  wire       RST,
	// Oscillator ticks (one-cycle enables)
	input  wire       MAIN_TICK,
	input  wire       SUB_TICK,
	// Accumulator transfers
	input  wire [7:0] ACC_IN,
	input  wire [2:0] MODE_WR_DATA,
	input  wire       MODE_WR,
	input  wire       KEY_WAKE_WR,
	input  wire       PULLUP_WR,
	// Power-down instructions
	input  wire       SLEEP_CLOCK_ON,
	input  wire       SLEEP_ALL_STOP,
	// Wake sources
	input  wire [7:0] KEY_PINS,
	input  wire       INT0_PIN,
	input  wire [3:0] IRQ_CONTROL_ONE,
	input  wire       TIMER_FOUR_FLAG,
	// Status and controls
	output reg  [2:0] CLOCK_MODE,
	output reg  [7:0] KEY_WAKE_READ,
	output reg  [7:0] KEY_PULLUP,
	output reg        MAIN_OSC_EN,
	output reg        SUB_OSC_EN,
	output reg        SUB_SELECTED,
	output reg        INSTR_TICK,
	output reg        SLEEPING,
	output reg        WARM_RESTART,
	output reg        POWER_DOWN_FLAG
);
	// One-hot sleep sequencer states
	localparam ST_RUN  = 4'h1;
	localparam ST_SLP1 = 4'h2;
	localparam ST_SLP2 = 4'h4;
	localparam ST_STAB = 4'h8;

	// Sequencer
	reg  [3:0]  state_r;
	reg  [3:0]  state_nxt;
	reg  [15:0] stab_r;
	reg  [15:0] stab_nxt;
	reg         t4_entry_r;
	reg         t4_entry_nxt;

	// Key edge detection
	reg  [7:0]  key_prev_r;

	// Next values of the registered outputs
	reg  [2:0]  mode_nxt;
	reg  [7:0]  key_wake_nxt;
	reg  [7:0]  pullup_nxt;
	reg         main_en_nxt;
	reg         sub_en_nxt;
	reg         sub_sel_nxt;
	reg         sleeping_nxt;
	reg         warm_nxt;
	reg         pd_flag_nxt;

	// Decoded conditions
	wire        in_run;
	wire        in_slp1;
	wire        in_slp2;
	wire        in_stab;
	wire        stab_done;
	wire        going_to_sleep;
	wire        key_fall;
	wire        lvl_match;
	wire        wake_ext;
	wire        wake_t4;
	wire        wake;
	wire        osc_tick;
	wire        div_pulse;

	assign in_run    = (state_r == ST_RUN);
	assign in_slp1   = (state_r == ST_SLP1);
	assign in_slp2   = (state_r == ST_SLP2);
	assign in_stab   = (state_r == ST_STAB);
	assign stab_done = ({16'h0000, stab_r} >= STAB_CYC - 1);

	assign going_to_sleep = (state_nxt == ST_SLP1) || (state_nxt == ST_SLP2);

	// Previous pin sample resets high, so a low pin after reset counts as a falling edge
	assign key_fall  = |(key_prev_r & ~KEY_PINS & KEY_WAKE_READ);
	// Level wake only; the interrupt request flag is not touched here
	assign lvl_match = (INT0_PIN == IRQ_CONTROL_ONE[`CPW_IRQ_LVL_BIT]);
	assign wake_ext  = key_fall | lvl_match;

	// Live timer flag counts only in clock-on sleep; all-stop sleep sees
	// only a flag that was already set when the sleep strobe was taken
	assign wake_t4 = in_slp1 ? TIMER_FOUR_FLAG : t4_entry_r;
	assign wake    = wake_ext | wake_t4;

	assign osc_tick = CLOCK_MODE[`CPW_SEL_BIT] ? SUB_TICK : MAIN_TICK;

	cpw_div3 u_div (
		.clk   (CLK),
		.rst   (RST),
		.tick  (osc_tick),
		.run   (in_run),
		.pulse (div_pulse)
	);

	// Sleep sequencer
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				// Flag already set still enters sleep, then leaves at once
				if (SLEEP_CLOCK_ON)
					state_nxt = ST_SLP1;
				else if (SLEEP_ALL_STOP)
					state_nxt = ST_SLP2;
			end
			ST_SLP1: begin
				if (wake)
					state_nxt = ST_STAB;
			end
			ST_SLP2: begin
				if (wake)
					state_nxt = ST_STAB;
			end
			ST_STAB: begin
				if (stab_done)
					state_nxt = ST_RUN;
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	// Stabilisation counter runs only while waiting after a wake
	always @* begin
		if (in_stab)
			stab_nxt = stab_r + 16'h0001;
		else
			stab_nxt = 16'h0000;
	end

	// Timer flag as seen at the moment the sleep strobe is taken
	always @* begin
		if (in_run)
			t4_entry_nxt = TIMER_FOUR_FLAG;
		else
			t4_entry_nxt = t4_entry_r;
	end

	// Accumulator transfers are honoured only while running
	always @* begin
		mode_nxt     = CLOCK_MODE;
		key_wake_nxt = KEY_WAKE_READ;
		pullup_nxt   = KEY_PULLUP;
		if (in_run && MODE_WR)
			mode_nxt = MODE_WR_DATA;
		if (in_run && KEY_WAKE_WR)
			key_wake_nxt = ACC_IN;
		if (in_run && PULLUP_WR)
			pullup_nxt = ACC_IN;
	end

	// Oscillator enables
	always @* begin
		// Main oscillator stops in either sleep and when its stop bit is set;
		// software must then wait for it before going back to it
		main_en_nxt = !CLOCK_MODE[`CPW_STOP_BIT] && !going_to_sleep;
		// Sub oscillator keeps running except in all-stop sleep
		sub_en_nxt  = (state_nxt != ST_SLP2);
	end

	// Clock mode is retained through sleep, so a warm start reuses it
	always @* begin
		sub_sel_nxt = CLOCK_MODE[`CPW_SEL_BIT];
	end

	// Sleep and warm start status
	always @* begin
		sleeping_nxt = going_to_sleep;
		warm_nxt     = 1'b0;
		pd_flag_nxt  = POWER_DOWN_FLAG;
		if (in_stab && state_nxt == ST_RUN) begin
			warm_nxt    = 1'b1;
			pd_flag_nxt = 1'b1;
		end
	end

	// Internal state
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_r    <= ST_RUN;
			stab_r     <= 16'h0000;
			t4_entry_r <= 1'b0;
			key_prev_r <= 8'hff;
		end else begin
			state_r    <= state_nxt;
			stab_r     <= stab_nxt;
			t4_entry_r <= t4_entry_nxt;
			key_prev_r <= KEY_PINS;
		end
	end

	// Registered outputs
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			CLOCK_MODE      <= `CPW_MODE_RST;
			KEY_WAKE_READ   <= `CPW_KEY_RST;
			KEY_PULLUP      <= `CPW_KEY_RST;
			MAIN_OSC_EN     <= 1'b1;
			SUB_OSC_EN      <= 1'b1;
			SUB_SELECTED    <= 1'b0;
			INSTR_TICK      <= 1'b0;
			SLEEPING        <= 1'b0;
			WARM_RESTART    <= 1'b0;
			POWER_DOWN_FLAG <= 1'b0;
		end else begin
			CLOCK_MODE      <= mode_nxt;
			KEY_WAKE_READ   <= key_wake_nxt;
			KEY_PULLUP      <= pullup_nxt;
			MAIN_OSC_EN     <= main_en_nxt;
			SUB_OSC_EN      <= sub_en_nxt;
			SUB_SELECTED    <= sub_sel_nxt;
			INSTR_TICK      <= div_pulse;
			SLEEPING        <= sleeping_nxt;
			WARM_RESTART    <= warm_nxt;
			POWER_DOWN_FLAG <= pd_flag_nxt;
		end
	end
endmodule // cpw_top

//--- bench/cpw_top_assertions.sv
// Checks on the clock select and wake ports
`timescale 1ns/10ps
module cpw_chk #(parameter STAB_CYC = 16) (
	input wire       CLK, RST, MAIN_OSC_EN, SUB_OSC_EN, SUB_SELECTED, INSTR_TICK,
	input wire       SLEEPING, WARM_RESTART, POWER_DOWN_FLAG, INT0_PIN, TIMER_FOUR_FLAG,
	input wire [2:0] CLOCK_MODE,
	input wire [3:0] IRQ_CONTROL_ONE,
	input wire [7:0] KEY_WAKE_READ, KEY_PINS
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// Wake plus the stabilisation wait fits well inside this bound
	sequence s_warm; ##[1:40] WARM_RESTART; endsequence
	property p_cold; $fell(RST) |-> CLOCK_MODE == 3'h0 && !POWER_DOWN_FLAG; endproperty
	a_cold: assert property (p_cold) else $error("bad cold state");
	property p_warm; WARM_RESTART |=> POWER_DOWN_FLAG && !WARM_RESTART; endproperty
	a_warm: assert property (p_warm) else $error("bad warm flag");
	property p_src; WARM_RESTART |-> SUB_SELECTED == CLOCK_MODE[0]; endproperty
	a_src: assert property (p_src) else $error("source lost");
	property p_div; INSTR_TICK |=> !INSTR_TICK [*2]; endproperty
	a_div: assert property (p_div) else $error("tick too fast");
	property p_stop; $rose(CLOCK_MODE[1]) |-> ##[0:1] !MAIN_OSC_EN; endproperty
	a_stop: assert property (p_stop) else $error("main runs");
	property p_key; SLEEPING && |($past(KEY_PINS) & ~KEY_PINS & KEY_WAKE_READ) |-> s_warm; endproperty
	a_key: assert property (p_key) else $error("no key wake");
	property p_lvl; SLEEPING && INT0_PIN == IRQ_CONTROL_ONE[2] |-> s_warm; endproperty
	a_lvl: assert property (p_lvl) else $error("no level wake");
	property p_t4; SLEEPING && SUB_OSC_EN && TIMER_FOUR_FLAG |-> s_warm; endproperty
	a_t4: assert property (p_t4) else $error("no timer wake");
endmodule // cpw_chk
bind cpw_top cpw_chk #(.STAB_CYC(STAB_CYC)) i_cpw_chk (.*);

//--- bench/cpw_far.sv
// Oscillators and key pins seen from outside
`timescale 1ns/10ps
module cpw_far (
	input wire        CLK, MAIN_OSC_EN, SUB_OSC_EN,
	input wire  [7:0] drop,
	output logic      MAIN_TICK = 1'b0,
	output logic      SUB_TICK = 1'b0,
	output wire [7:0] KEY_PINS
);
	logic [1:0] div_r = 2'h0;
	// Pull-ups hold idle pins high, so only a commanded drop goes low
	assign KEY_PINS = ~drop;
	always @(posedge CLK) begin
		div_r <= div_r + 2'h1;
		MAIN_TICK <= MAIN_OSC_EN;
		SUB_TICK <= SUB_OSC_EN && div_r == 2'h0;
	end
endmodule // cpw_far

//--- bench/cpw_top_tb_top.sv
// Self-checking bench for the clock select and wake block
`timescale 1ns/10ps
`include "cpw_consts.vh"
module cpw_top_tb_top;
	logic CLK = 0, RST = 1, INT0_PIN = 0, TIMER_FOUR_FLAG = 0;
	logic [4:0] strb = 5'h00;
	logic [2:0] MODE_WR_DATA = 3'h0, m[4] = '{3'h1, 3'h3, 3'h1, 3'h0};
	logic [3:0] IRQ_CONTROL_ONE = 4'h4;
	logic [7:0] ACC_IN = 8'h00, drop = 8'h00, k;
	wire MAIN_TICK, SUB_TICK, MAIN_OSC_EN, SUB_OSC_EN, SUB_SELECTED, INSTR_TICK, SLEEPING;
	wire WARM_RESTART, POWER_DOWN_FLAG;
	wire [2:0] CLOCK_MODE;
	wire [7:0] KEY_PINS, KEY_WAKE_READ, KEY_PULLUP;
	int err_count = 0, comparisons = 0, cyc = 0, i, j, n;
	cpw_top i_cpw_top (.MODE_WR(strb[4]), .KEY_WAKE_WR(strb[3]), .PULLUP_WR(strb[2]),
		.SLEEP_CLOCK_ON(strb[1]), .SLEEP_ALL_STOP(strb[0]), .*);
	cpw_far i_cpw_far (.*);
	initial forever #5 CLK = ~CLK;
	always @(posedge CLK) if (++cyc == 5000) begin err_count++; finish_test; end
	function [7:0] osc_exp(input [2:0] md);
		osc_exp = {6'h00, !md[1], md[0]};
	endfunction
	task chk(input [7:0] g, e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %h, expected %h", $time, g, e);
		end
	endtask
	task go(input [4:0] s, input [7:0] a);
		@(posedge CLK) strb <= s;
		ACC_IN <= a;
		MODE_WR_DATA <= a[2:0];
		@(posedge CLK) strb <= 5'h00;
		repeat (2) @(posedge CLK);
		#1;
	endtask
	task wake;
		for (i = 0; i < 200 && WARM_RESTART !== 1'b1; i++) #10;
		chk(i < 200, 1);
		#20;
		chk({SLEEPING, POWER_DOWN_FLAG}, 1);
	endtask
	task finish_test;
		$display("errors %0d of %0d comparisons", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		k = 8'($urandom(32'hfa999e78));
		repeat (10) @(posedge CLK);
		RST <= 0;
		IRQ_CONTROL_ONE <= 4'($urandom) | 4'h4;
		@(posedge CLK) #1;
		chk({CLOCK_MODE, POWER_DOWN_FLAG}, 0);
		k = 8'($urandom) | 8'h01;
		go(5'h08, k);
		chk(KEY_WAKE_READ, k);
		go(5'h04, ~k);
		chk(KEY_PULLUP, ~k);
		for (j = 0; j < 4; j++) begin
			repeat (20) @(posedge CLK);
			go(5'h10, {5'h00, m[j]});
			chk({6'h00, MAIN_OSC_EN, SUB_SELECTED}, osc_exp(m[j]));
		end
		n = 0;
		repeat (30) begin
			@(posedge CLK) #1;
			n += INSTR_TICK;
		end
		chk(n, 10);
		go(5'h10, 8'h01);
		go(5'h02, 8'h00);
		chk({SLEEPING, SUB_OSC_EN, MAIN_OSC_EN}, 6);
		@(posedge CLK) drop <= 8'h01;
		wake;
		chk(SUB_SELECTED, 1);
		@(posedge CLK) drop <= 8'h00;
		repeat (20) @(posedge CLK);
		go(5'h10, 8'h00);
		go(5'h01, 8'h00);
		@(posedge CLK) TIMER_FOUR_FLAG <= 1;
		repeat (60) @(posedge CLK);
		#1;
		chk({SLEEPING, SUB_OSC_EN, MAIN_OSC_EN}, 4);
		@(posedge CLK) INT0_PIN <= 1;
		wake;
		@(posedge CLK) INT0_PIN <= 0;
		go(5'h02, 8'h00);
		wake;
		go(5'h01, 8'h00);
		wake;
		@(posedge CLK) TIMER_FOUR_FLAG <= 0;
		finish_test;
	end
endmodule // cpw_top_tb_top
